// File: hdl/ccdr_readout_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccdr_defs.svh"

module ccdr_readout_ctrl #(
  parameter int LINES     = `CCDR_LINES,
  parameter int HREG      = `CCDR_HREG_LEN,
  parameter int PIX_CYC   = `CCDR_PIXEL_CYC,
  parameter int VPULSE    = `CCDR_VPULSE_CYC,
  parameter int HSET_CYC  = `CCDR_HSETUP_CYC,
  parameter int CLR_CYC   = `CCDR_CLEAR_CYC,
  parameter int INTEG_W   = 32
) (
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic                 start_frame,
  input  wire logic [INTEG_W-1:0]   integ_cycles,
  output logic                      vertical_phase_a,
  output logic                      vertical_phase_b,
  output logic                      horizontal_phase_a,
  output logic                      horizontal_phase_b,
  output logic                      node_clear,
  output logic                      sample_strobe,
  output ccdr_pkg::ccdr_pix_class_type pixel_class,
  output logic                      ref_suspect,
  output logic [$clog2(LINES)-1:0]  line_index,
  output logic [$clog2(HREG+1)-1:0] pixel_index,
  output logic                      busy,
  output logic                      frame_done
);
  import ccdr_pkg::*;

  localparam int LW   = $clog2(LINES);
  localparam int PW   = $clog2(HREG + 1);
  localparam int CW   = $clog2(PIX_CYC);
  // One spare count keeps the step counter legal even for one-cycle steps
  localparam int VW   = $clog2((VPULSE > HSET_CYC ? VPULSE : HSET_CYC) + 1);
  localparam int HALF = PIX_CYC / 2;

  // Geometry must add up, and the clear must finish before the packet lands
  if (`CCDR_DARK_LEAD + `CCDR_ACTIVE_COLS + `CCDR_DARK_TRAIL != `CCDR_COLUMNS) begin : g_cols
    $error("ccdr_readout_ctrl: column count mismatch");
  end
  if (`CCDR_DUMMY_LEAD + `CCDR_COLUMNS + `CCDR_DUMMY_TRAIL != HREG) begin : g_hreg
    $error("ccdr_readout_ctrl: horizontal register length mismatch");
  end
  if (`CCDR_DARK_TOP + `CCDR_ACTIVE_LINES + `CCDR_DARK_BOT != LINES) begin : g_lines
    $error("ccdr_readout_ctrl: line count mismatch");
  end
  if (PIX_CYC < 4 || CLR_CYC >= HALF || VPULSE < 1 || HSET_CYC < 1) begin : g_time
    $error("ccdr_readout_ctrl: timing counts unusable");
  end

  typedef struct packed {
    ccdr_state_type     st;
    logic [INTEG_W-1:0] integ;
    logic [VW-1:0]      vcnt;
    logic [LW-1:0]      line;
    logic [PW-1:0]      pix;
    logic               va;
    logic               vb;
    logic               ha;
    logic               hb;
    logic               clr;
    logic               smp;
    logic               susp;
    ccdr_pix_class_type cls;
    logic               busy;
    logic               done;
  } ccdr_seq_type;

  ccdr_seq_type s_r;
  ccdr_seq_type s_nxt;
  logic [CW-1:0] cnt;
  logic          slot_end;
  logic [CW-1:0] cnt_nxt;

  ccdr_pixel_timer #(
    .PIX_CYC (PIX_CYC),
    .CW      (CW)
  ) u_timer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .cnt      (cnt),
    .slot_end (slot_end)
  );

  function automatic ccdr_pix_class_type pix_class(input int p, input int l);
    int c;
    c = p - `CCDR_DUMMY_LEAD;
    if (p < `CCDR_DUMMY_LEAD || c >= `CCDR_COLUMNS) begin
      pix_class = CCDR_PIX_DUMMY;
    end else if (l < `CCDR_DARK_TOP || l >= `CCDR_DARK_TOP + `CCDR_ACTIVE_LINES) begin
      pix_class = CCDR_PIX_DARK;
    end else if (c < `CCDR_DARK_LEAD || c >= `CCDR_DARK_LEAD + `CCDR_ACTIVE_COLS) begin
      pix_class = CCDR_PIX_DARK;
    end else begin
      pix_class = CCDR_PIX_ACTIVE;
    end
  endfunction : pix_class

  // Dark pixels on the border of the active area or the chip, or in early lines
  function automatic logic pix_suspect(input int p, input int l);
    int c;
    c = p - `CCDR_DUMMY_LEAD;
    pix_suspect = (l < `CCDR_SUSPECT_LINES) || (l == `CCDR_DARK_TOP - 1) ||
                  (l == `CCDR_DARK_TOP + `CCDR_ACTIVE_LINES) || (l == LINES - 1) ||
                  (c == 0) || (c == `CCDR_DARK_LEAD - 1) ||
                  (c == `CCDR_DARK_LEAD + `CCDR_ACTIVE_COLS) || (c == `CCDR_COLUMNS - 1);
  endfunction : pix_suspect

  assign cnt_nxt = slot_end ? '0 : cnt + 1'b1;

  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      CCDR_ST_IDLE: begin
        if (start_frame) begin
          s_nxt.st    = CCDR_ST_INTEG;
          s_nxt.integ = integ_cycles;
          s_nxt.line  = '0;
        end
      end
      CCDR_ST_INTEG: begin
        if (s_r.integ == '0) begin
          s_nxt.st   = CCDR_ST_VA;
          s_nxt.vcnt = '0;
        end else begin
          s_nxt.integ = s_r.integ - 1'b1;
        end
      end
      CCDR_ST_VA, CCDR_ST_VB, CCDR_ST_VC: begin
        if (s_r.vcnt == VW'(VPULSE - 1)) begin
          s_nxt.vcnt = '0;
          s_nxt.st   = (s_r.st == CCDR_ST_VA) ? CCDR_ST_VB :
                       (s_r.st == CCDR_ST_VB) ? CCDR_ST_VC : CCDR_ST_HSET;
        end else begin
          s_nxt.vcnt = s_r.vcnt + 1'b1;
        end
      end
      CCDR_ST_HSET: begin
        // Setup time first, then align the shift to a pixel slot boundary
        if (s_r.vcnt < VW'(HSET_CYC - 1)) begin
          s_nxt.vcnt = s_r.vcnt + 1'b1;
        end else if (slot_end) begin
          s_nxt.st  = CCDR_ST_HSHIFT;
          s_nxt.pix = '0;
        end
      end
      CCDR_ST_HSHIFT: begin
        if (slot_end) begin
          if (s_r.pix == PW'(HREG)) begin
            s_nxt.vcnt = '0;
            if (s_r.line == LW'(LINES - 1)) begin
              s_nxt.st = CCDR_ST_DONE;
            end else begin
              s_nxt.st   = CCDR_ST_VA;
              s_nxt.line = s_r.line + 1'b1;
            end
          end else begin
            s_nxt.pix = s_r.pix + 1'b1;
          end
        end
      end
      CCDR_ST_DONE: begin
        s_nxt.st = CCDR_ST_IDLE;
      end
      default: begin
        s_nxt.st = CCDR_ST_IDLE;
      end
    endcase
    // Pins follow the next state so they line up with the registered state
    s_nxt.va   = (s_nxt.st == CCDR_ST_VA);
    s_nxt.vb   = (s_nxt.st == CCDR_ST_VB);
    s_nxt.hb   = (s_nxt.st == CCDR_ST_HSHIFT) && (cnt_nxt < CW'(HALF));
    s_nxt.ha   = !s_nxt.hb;
    s_nxt.clr  = (cnt_nxt < CW'(CLR_CYC));
    s_nxt.smp  = (s_nxt.st == CCDR_ST_HSHIFT) && (cnt_nxt == CW'(PIX_CYC - 1));
    s_nxt.cls  = pix_class(int'(s_nxt.pix), int'(s_nxt.line));
    s_nxt.susp = (s_nxt.st == CCDR_ST_HSHIFT) && (s_nxt.cls == CCDR_PIX_DARK) &&
                 pix_suspect(int'(s_nxt.pix), int'(s_nxt.line));
    s_nxt.busy = (s_nxt.st != CCDR_ST_IDLE);
    s_nxt.done = (s_nxt.st == CCDR_ST_DONE);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r    <= '0;
      s_r.ha <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign vertical_phase_a   = s_r.va;
  assign vertical_phase_b   = s_r.vb;
  assign horizontal_phase_a = s_r.ha;
  assign horizontal_phase_b = s_r.hb;
  assign node_clear         = s_r.clr;
  assign sample_strobe      = s_r.smp;
  assign pixel_class        = s_r.cls;
  assign ref_suspect        = s_r.susp;
  assign line_index         = s_r.line;
  assign pixel_index        = s_r.pix;
  assign busy               = s_r.busy;
  assign frame_done         = s_r.done;

  // Gap between clear pulses, only read by the checks below
  logic [CW:0] clr_gap_r;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clr_gap_r <= '0;
    end else begin
      clr_gap_r <= node_clear ? '0 : clr_gap_r + 1'b1;
    end
  end

  property p_integ_still;
    @(posedge core_clk) disable iff (!nrst)
    (s_r.st == CCDR_ST_INTEG) |-> !vertical_phase_a && !vertical_phase_b && $stable(vertical_phase_b);
  endproperty
  a_integ_still: assert property (p_integ_still) else $error("vertical phase moved in integration");

  property p_ha_on_vb_fall;
    @(posedge core_clk) disable iff (!nrst)
    $fell(vertical_phase_b) |-> horizontal_phase_a && $past(horizontal_phase_a) && !horizontal_phase_b;
  endproperty
  a_ha_on_vb_fall: assert property (p_ha_on_vb_fall) else $error("h phase a low at v phase b fall");

  property p_h_compl;
    @(posedge core_clk) disable iff (!nrst)
    (s_r.st == CCDR_ST_HSHIFT) |-> (horizontal_phase_a != horizontal_phase_b);
  endproperty
  a_h_compl: assert property (p_h_compl) else $error("horizontal phases not complementary");

  property p_clear_after_sample;
    @(posedge core_clk) disable iff (!nrst)
    sample_strobe |-> !node_clear ##1 node_clear [*2];
  endproperty
  a_clear_after_sample: assert property (p_clear_after_sample) else $error("clear not after sample");

  property p_clear_running;
    @(posedge core_clk) disable iff (!nrst)
    clr_gap_r < (CW+1)'(PIX_CYC - CLR_CYC + 1);
  endproperty
  a_clear_running: assert property (p_clear_running) else $error("node clear stopped");

  property p_integ_length;
    @(posedge core_clk) disable iff (!nrst)
    (s_r.st == CCDR_ST_IDLE && start_frame && integ_cycles == 3) |=> (s_r.st == CCDR_ST_INTEG) [*4] ##1 vertical_phase_a;
  endproperty
  a_integ_length: assert property (p_integ_length) else $error("integration length wrong");

  property p_frame_end;
    @(posedge core_clk) disable iff (!nrst)
    $rose(frame_done) |-> ($past(line_index) == LW'(LINES - 1)) && ($past(pixel_index) == PW'(HREG));
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame ended early");

  property p_class_edges;
    @(posedge core_clk) disable iff (!nrst)
    sample_strobe |-> ((pixel_index < PW'(`CCDR_DUMMY_LEAD)) == (pixel_class == CCDR_PIX_DUMMY && pixel_index < PW'(`CCDR_DUMMY_LEAD)))
      && ((line_index < LW'(`CCDR_DARK_TOP)) -> (pixel_class != CCDR_PIX_ACTIVE));
  endproperty
  a_class_edges: assert property (p_class_edges) else $error("pixel class wrong");

  property p_first_lines_suspect;
    @(posedge core_clk) disable iff (!nrst)
    (sample_strobe && line_index < LW'(`CCDR_SUSPECT_LINES) && pixel_class == CCDR_PIX_DARK) |-> ref_suspect;
  endproperty
  a_first_lines_suspect: assert property (p_first_lines_suspect) else $error("early dark not suspect");

  c_frame_done: cover property (@(posedge core_clk) disable iff (!nrst) frame_done);
  c_active_px: cover property (@(posedge core_clk) disable iff (!nrst) sample_strobe && pixel_class == CCDR_PIX_ACTIVE);
  c_line_turn: cover property (@(posedge core_clk) disable iff (!nrst) $fell(vertical_phase_b) && line_index != '0);

endmodule : ccdr_readout_ctrl
`default_nettype wire

// File: hdl/ccdr_defs.svh
`ifndef CCDR_DEFS_SVH
`define CCDR_DEFS_SVH

// Clock and printed times
`define CCDR_CLK_PERIOD_PS 8000
`define CCDR_T_PIXEL_NS    67
`define CCDR_T_VPULSE_NS   4000
`define CCDR_T_HSETUP_NS   500
`define CCDR_T_CLEAR_NS    10
// Least times round up to whole cycles
`define CCDR_NS_TO_CYC(t) ((((t) * 1000) + `CCDR_CLK_PERIOD_PS - 1) / `CCDR_CLK_PERIOD_PS)
`define CCDR_PIXEL_CYC     `CCDR_NS_TO_CYC(`CCDR_T_PIXEL_NS)
`define CCDR_VPULSE_CYC    `CCDR_NS_TO_CYC(`CCDR_T_VPULSE_NS)
`define CCDR_HSETUP_CYC    `CCDR_NS_TO_CYC(`CCDR_T_HSETUP_NS)
`define CCDR_CLEAR_CYC     `CCDR_NS_TO_CYC(`CCDR_T_CLEAR_NS)

// Array geometry
`define CCDR_COLUMNS       1552
`define CCDR_LINES         1032
`define CCDR_HREG_LEN      1564
`define CCDR_ACTIVE_COLS   1536
`define CCDR_ACTIVE_LINES  1024
`define CCDR_DARK_LEAD     4
`define CCDR_DARK_TRAIL    12
`define CCDR_DARK_TOP      4
`define CCDR_DARK_BOT      4
`define CCDR_DUMMY_LEAD    10
`define CCDR_DUMMY_TRAIL   2
`define CCDR_SUSPECT_LINES 2

`endif

// File: hdl/ccdr_pkg.sv
package ccdr_pkg;

  // Gray order along idle, integrate, vertical steps, setup, shift, done
  typedef enum logic [2:0] {
    CCDR_ST_IDLE   = 3'h0,
    CCDR_ST_INTEG  = 3'h1,
    CCDR_ST_VA     = 3'h3,
    CCDR_ST_VB     = 3'h2,
    CCDR_ST_VC     = 3'h6,
    CCDR_ST_HSET   = 3'h7,
    CCDR_ST_HSHIFT = 3'h5,
    CCDR_ST_DONE   = 3'h4
  } ccdr_state_type;

  typedef enum logic [1:0] {
    CCDR_PIX_DUMMY  = 2'h0,
    CCDR_PIX_DARK   = 2'h1,
    CCDR_PIX_ACTIVE = 2'h2
  } ccdr_pix_class_type;

endpackage : ccdr_pkg

// File: hdl/ccdr_pixel_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccdr_defs.svh"

// Free-running pixel slot divider; never stops so the node clear keeps running
module ccdr_pixel_timer #(
  parameter int PIX_CYC = `CCDR_PIXEL_CYC,
  parameter int CW      = $clog2(PIX_CYC)
) (
  input  wire logic          core_clk,
  input  wire logic          nrst,
  output logic [CW-1:0]      cnt,
  output logic               slot_end
);
  import ccdr_pkg::*;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          last;
  } ccdr_tmr_type;

  ccdr_tmr_type t_r;
  ccdr_tmr_type t_nxt;

  if (PIX_CYC < 2) begin : g_bad
    $error("ccdr_pixel_timer: PIX_CYC too small");
  end

  always_comb begin
    t_nxt      = t_r;
    t_nxt.cnt  = t_r.last ? '0 : t_r.cnt + 1'b1;
    t_nxt.last = (t_nxt.cnt == CW'(PIX_CYC - 1));
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end

  assign cnt      = t_r.cnt;
  assign slot_end = t_r.last;

endmodule : ccdr_pixel_timer
`default_nettype wire

// File: verif/ccdr_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none

// Behavioural sensor: tracks which packet sits on the sense node
module ccdr_sensor_model (
  input  wire logic  flush_n,
  input  wire logic  vertical_phase_b,
  input  wire logic  horizontal_phase_a,
  input  wire logic  horizontal_phase_b,
  input  wire logic  node_clear,
  output logic [1:0] sense_kind,
  output int         hazard_cnt,
  output int         overlap_cnt
);
  import ccdr_pkg::*;
  int   row_r;
  int   col_r;
  logic pend_r;

  function automatic logic [1:0] kind_of(input int r, input int k);
    if (k < 10 || k > 1561) return CCDR_PIX_DUMMY;
    if (k < 14 || k > 1549) return CCDR_PIX_DARK;
    if (r < 4 || r > 1027) return CCDR_PIX_DARK;
    return CCDR_PIX_ACTIVE;
  endfunction : kind_of

  // Flush stands for power-up; a real array would need a dump frame
  task automatic flush();
    row_r = -1;
    col_r = 0;
    pend_r = 1'b0;
    sense_kind = 2'h3;
  endtask : flush

  initial begin
    hazard_cnt = 0;
    overlap_cnt = 0;
    flush();
  end

  always @(negedge flush_n) flush();

  always @(negedge vertical_phase_b) begin
    if (flush_n === 1'b1) begin
      if (horizontal_phase_a !== 1'b1) hazard_cnt++;
      row_r = (row_r + 1) % 1032;
      col_r = 0;
    end
  end

  always @(negedge horizontal_phase_b) begin
    if (flush_n === 1'b1) begin
      if (pend_r) overlap_cnt++;
      sense_kind = kind_of(row_r, col_r);
      pend_r = 1'b1;
      col_r++;
    end
  end

  // Cleared node sits at the drain level, never keeps the old packet
  always @(posedge node_clear) begin
    pend_r = 1'b0;
    sense_kind = 2'h3;
  end
endmodule : ccdr_sensor_model

`default_nettype wire

// File: verif/ccdr_readout_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none

module ccdr_readout_ctrl_tb;
  import ccdr_pkg::*;
  typedef struct packed {
    logic [10:0]        line;
    logic [10:0]        pix;
    ccdr_pix_class_type cls;
    logic               sus;
  } ccdr_row_type;
  localparam logic [2:0] VWALK [5] = '{3'h5, 3'h5, 3'h3, 3'h3, 3'h1};

  logic               core_clk;
  logic               nrst;
  logic               start_frame;
  logic [31:0]        integ_cycles;
  logic               vertical_phase_a;
  logic               vertical_phase_b;
  logic               horizontal_phase_a;
  logic               horizontal_phase_b;
  logic               node_clear;
  logic               sample_strobe;
  ccdr_pix_class_type pixel_class;
  logic               ref_suspect;
  logic [10:0]        line_index;
  logic [10:0]        pixel_index;
  logic               busy;
  logic               frame_done;
  logic [1:0]         sense_kind;
  int                 hazard_cnt;
  int                 overlap_cnt;
  int                 failures;
  int                 checks_done;
  int                 cyc;
  int                 bad_comp;
  ccdr_row_type       rows [20];

  // Short vertical and setup steps; geometry stays full size
  ccdr_readout_ctrl #(.PIX_CYC(8), .VPULSE(2), .HSET_CYC(2)) dut (
    .core_clk, .nrst, .start_frame, .integ_cycles,
    .vertical_phase_a, .vertical_phase_b, .horizontal_phase_a, .horizontal_phase_b,
    .node_clear, .sample_strobe, .pixel_class, .ref_suspect,
    .line_index, .pixel_index, .busy, .frame_done
  );

  ccdr_sensor_model sensor (
    .flush_n(nrst), .vertical_phase_b, .horizontal_phase_a, .horizontal_phase_b,
    .node_clear, .sense_kind, .hazard_cnt, .overlap_cnt
  );

  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // Ceiling covers five full lines of readout with margin
  always @(posedge core_clk) begin
    cyc++;
    if (nrst === 1'b1 && horizontal_phase_a === horizontal_phase_b) bad_comp++;
    if (cyc == 80000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk_v(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk_v

  task automatic chk_i(input string n, input int e, input int g);
    checks_done++;
    if (g != e) begin
      failures++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_i

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step

  task automatic reset_check();
    chk_v("reset_outputs", 16'h0020, {8'h0, vertical_phase_a, vertical_phase_b,
          horizontal_phase_a, horizontal_phase_b, node_clear, sample_strobe, busy, frame_done});
  endtask : reset_check

  // Start held high through integration with a new length: must be ignored
  task automatic start_check(input int n);
    int   k;
    int   clr;
    logic prev;
    k = 0;
    clr = 0;
    prev = 1'b1;
    start_frame = 1'b1;
    integ_cycles = n;
    while (busy !== 1'b1 && k < 4) begin
      step();
      k++;
    end
    chk_v("busy", 16'h1, {15'h0, busy});
    integ_cycles = 32'h3;
    k = 0;
    while (vertical_phase_a !== 1'b1 && k < n + 9) begin
      chk_v("vertical_idle", 16'h0, {15'h0, vertical_phase_b});
      if (node_clear === 1'b1 && prev !== 1'b1) clr++;
      prev = node_clear;
      step();
      k++;
    end
    start_frame = 1'b0;
    chk_i("integration_cycles", n + 1, k);
    chk_v("clear_running", 16'h1, {15'h0, clr >= (n + 1) / 8});
    for (int j = 0; j < 5; j++) begin
      chk_v("vertical_walk", {13'h0, VWALK[j]},
            {13'h0, vertical_phase_a, vertical_phase_b, horizontal_phase_a});
      step();
    end
    $display("test start_%0d done", n);
  endtask : start_check

  task automatic wait_slot(input logic [10:0] l, input logic [10:0] p);
    while (!(sample_strobe === 1'b1 && line_index === l && pixel_index === p)) step();
  endtask : wait_slot

  initial begin
    failures = 0;
    checks_done = 0;
    cyc = 0;
    bad_comp = 0;
    nrst = 1'b0;
    start_frame = 1'b0;
    integ_cycles = 32'h0;
    rows = '{
      '{11'h0, 11'h000, CCDR_PIX_DUMMY, 1'b0}, '{11'h0, 11'h009, CCDR_PIX_DUMMY, 1'b0},
      '{11'h0, 11'h00A, CCDR_PIX_DARK, 1'b1}, '{11'h0, 11'h00E, CCDR_PIX_DARK, 1'b1},
      '{11'h0, 11'h60D, CCDR_PIX_DARK, 1'b1}, '{11'h0, 11'h61A, CCDR_PIX_DUMMY, 1'b0},
      '{11'h0, 11'h61C, CCDR_PIX_DUMMY, 1'b0}, '{11'h1, 11'h014, CCDR_PIX_DARK, 1'b1},
      '{11'h4, 11'h009, CCDR_PIX_DUMMY, 1'b0}, '{11'h4, 11'h00A, CCDR_PIX_DARK, 1'b1},
      '{11'h4, 11'h00B, CCDR_PIX_DARK, 1'b0}, '{11'h4, 11'h00D, CCDR_PIX_DARK, 1'b1},
      '{11'h4, 11'h00E, CCDR_PIX_ACTIVE, 1'b0},
      '{11'h4, 11'h064, CCDR_PIX_ACTIVE, 1'b0}, '{11'h4, 11'h60D, CCDR_PIX_ACTIVE, 1'b0},
      '{11'h4, 11'h60E, CCDR_PIX_DARK, 1'b1}, '{11'h4, 11'h619, CCDR_PIX_DARK, 1'b1},
      '{11'h4, 11'h61A, CCDR_PIX_DUMMY, 1'b0}, '{11'h4, 11'h61B, CCDR_PIX_DUMMY, 1'b0},
      '{11'h5, 11'h000, CCDR_PIX_DUMMY, 1'b0}};
    repeat (16) step();
    reset_check();
    nrst = 1'b1;
    $display("test reset done");
    start_check(0);
    // Abort in mid-line twice; reset is asynchronous so outputs take their reset values at once
    for (int a = 0; a < 2; a++) begin
      repeat (300) step();
      nrst = 1'b0;
      #1;
      reset_check();
      repeat (3) step();
      nrst = 1'b1;
      $display("test abort done");
      if (a == 0) start_check(3);
    end
    start_check(37);
    for (int i = 0; i < 20; i++) begin
      wait_slot(rows[i].line, rows[i].pix);
      chk_v("pixel_class", {14'h0, rows[i].cls}, {14'h0, pixel_class});
      chk_v("sense_kind", {14'h0, rows[i].cls}, {14'h0, sense_kind});
      chk_v("ref_suspect", {15'h0, rows[i].sus}, {15'h0, ref_suspect});
      step();
      if (rows[i].pix != 11'h61C) chk_v("slot_walk", {5'h06, rows[i].pix + 11'h1},
          {2'h0, node_clear, horizontal_phase_b, 1'b0, pixel_index});
    end
    $display("test table done");
    chk_i("line_hazards", 0, hazard_cnt);
    chk_i("clear_overlaps", 0, overlap_cnt);
    chk_i("complement_faults", 0, bad_comp);
    close_out();
  end
endmodule : ccdr_readout_ctrl_tb

`default_nettype wire
